// *** design/ltc_cfg.svh ***
// Register offsets, field positions, reset values and counts of the lite timer
`ifndef LTC_CFG_SVH
`define LTC_CFG_SVH

// Register offsets
`define LTC_OFF_CSR2 8'h08
`define LTC_OFF_RELOAD 8'h09
`define LTC_OFF_CNT2 8'h0A
`define LTC_OFF_CSR1 8'h0B
`define LTC_OFF_CAPTURE 8'h0C
`define LTC_OFF_IRQ_STATUS 8'h0D
`define LTC_OFF_IRQ_MASK 8'h0E

// Field positions, control/status register 2
`define LTC_CSR2_TIMEBASE2_FLAG 0
`define LTC_CSR2_TIMEBASE2_IRQ_EN 1
// Field positions, control/status register 1
`define LTC_CSR1_TIMEBASE1_FLAG 3
`define LTC_CSR1_TIMEBASE1_IRQ_EN 4
`define LTC_CSR1_DBL 5
`define LTC_CSR1_ICF 6
`define LTC_CSR1_CAPTURE_IRQ_EN 7
// Field positions, interrupt status and mask
`define LTC_IRQ_TB1 0
`define LTC_IRQ_TB2 1
`define LTC_IRQ_CAP 2

// Reset values
`define LTC_RST_BYTE 8'h00
`define LTC_RST_CAP_FLAG 1'b0

// Counting
`define LTC_PRESCALE 32
`define LTC_PRE_LAST 5'h1F
`define LTC_CNT1_LAST 8'hF9
`define LTC_CNT2_LAST 8'hFF
`define LTC_TB_PERIOD_OSC 8000
`define LTC_TB_PERIOD_DBL_OSC 16000
`endif

// *** design/ltc_pkg.sv ***
// Shared types of the lite timer
package ltc_pkg;
  // One register byte
  typedef logic [7:0] ltc_byte_t;
  // Prescaler count
  typedef logic [4:0] ltc_pre_t;
endpackage

// *** design/ltc_tick_if.sv ***
// Tick and timebase signals passed between the lite timer modules
`timescale 1ns/1ps
interface ltc_tick_if;
  logic tick; // One cycle every 32 clocks
  ltc_pkg::ltc_byte_t cnt1; // Hidden timebase count
  logic tb1_evt; // Timebase flag event
  logic halt; // Full halt, counters stop
  logic dbl; // Doubled period selected
  modport timebase (output tick, output cnt1, output tb1_evt, input halt, input dbl);
  modport user (input tick, input cnt1, input tb1_evt, output halt, output dbl);
  modport counter (input tick);
endinterface

// *** design/ltc_timebase.sv ***
// Prescaler and hidden timebase counter
`timescale 1ns/1ps
`include "ltc_cfg.svh"
module ltc_timebase (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Tick and timebase
  ltc_tick_if.timebase tb
);
  ltc_pkg::ltc_pre_t pre; // Divide-by-32 prescaler
  logic half; // Odd wrap seen in doubled mode
  logic wrap; // Counter rolls F9 to 00
  logic pre_end; // Last prescaler state

  assign pre_end = (pre == `LTC_PRE_LAST) && !tb.halt;
  assign wrap = pre_end && (tb.cnt1 == `LTC_CNT1_LAST);
  // Tick is the last prescaler state itself, so halt stops both counters on one edge
  assign tb.tick = pre_end;

  // Prescaler; halt freezes it
  always_ff @(posedge clk) begin
    if (srst) begin
      pre <= 5'h00;
    end else begin
      pre <= tb.halt ? pre : pre + 5'h01;
    end
  end

  // Hidden counter from zero, wraps after 250 counts
  always_ff @(posedge clk) begin
    if (srst) begin
      tb.cnt1 <= `LTC_RST_BYTE;
    end else if (pre_end) begin
      tb.cnt1 <= wrap ? 8'h00 : tb.cnt1 + 8'h01;
    end
  end

  // Doubled period: event on every second wrap only
  always_ff @(posedge clk) begin
    if (srst) begin
      half <= 1'b0;
      tb.tb1_evt <= 1'b0;
    end else begin
      half <= tb.dbl ? (half ^ wrap) : 1'b0;
      tb.tb1_evt <= wrap && (!tb.dbl || half);
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (srst)
    tb.tick |=> !tb.tick [*8]) else $error("tick repeated within prescale window");
  a_cnt1_range: assert property (@(posedge clk) disable iff (srst)
    tb.cnt1 <= `LTC_CNT1_LAST) else $error("timebase count passed wrap value");
endmodule // ltc_timebase

// *** design/ltc_reload_cnt.sv ***
// Autoreload counter 2
`timescale 1ns/1ps
`include "ltc_cfg.svh"
module ltc_reload_cnt (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Tick
  ltc_tick_if.counter tb,
  // Reload and state
  input wire ltc_pkg::ltc_byte_t reload,
  output ltc_pkg::ltc_byte_t count,
  output logic ovf
);
  logic at_top; // Count at FF on a tick

  assign at_top = tb.tick && (count == `LTC_CNT2_LAST);

  // Reload only on overflow, so late writes wait for it
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= `LTC_RST_BYTE;
      ovf <= 1'b0;
    end else begin
      ovf <= at_top;
      if (at_top) begin
        count <= reload;
      end else if (tb.tick) begin
        count <= count + 8'h01;
      end
    end
  end

  a_reload_apply: assert property (@(posedge clk) disable iff (srst)
    at_top |=> count == $past(reload)) else $error("overflow did not take reload");
endmodule // ltc_reload_cnt

// *** design/ltc_timer.sv ***
// Lite timebase and capture timer: registers, flags, capture and interrupts
// Behaviour
// - hidden counter counts from zero at clk/32
// - hidden counter wraps F9 to 00, event
// - period select gives 8000 or 16000 clocks
// - overflow sets timebase-1 flag, enabled interrupt
// - reading csr1 clears timebase-1 flag, writes ignored
// - counter 2 counts at clk/32 from reload
// - counter 2 overflow at FF reloads value
// - new reload applied at next overflow only
// - counter 2 overflow sets flag, read clears
// - pin edge latches hidden counter, sets flag
// - capture blocked while capture flag set
// - reading capture register clears capture flag
// - counters stop only in full halt
// - three flags drive separate gated interrupt lines
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "ltc_cfg.svh"
module ltc_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] addr,
  input wire ltc_pkg::ltc_byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output ltc_pkg::ltc_byte_t rd_data,
  // Pins and power mode
  input wire logic capture_pin,
  input wire logic halt_mode,
  // Interrupts
  output logic irq,
  output logic irq_timebase1,
  output logic irq_timebase2,
  output logic irq_capture
);
  // Shared tick and timebase signals
  ltc_tick_if tbi ();

  // Software-written control bits
  logic timebase1_irq_en; // Timebase 1 enable
  logic timebase2_irq_en; // Timebase 2 enable
  logic capture_irq_en; // Capture enable
  logic period_double_sel; // Doubled timebase period
  ltc_pkg::ltc_byte_t counter2_reload; // Reload value
  ltc_pkg::ltc_byte_t irq_mask; // Summary interrupt mask

  // Hardware flags and captured state
  logic timebase1_flag; // Timebase 1 overflow seen
  logic timebase2_flag; // Counter 2 overflow seen
  logic capture_flag; // Capture taken
  ltc_pkg::ltc_byte_t capture_value; // Last captured count
  ltc_pkg::ltc_byte_t irq_status; // Sticky event record
  ltc_pkg::ltc_byte_t counter2_value; // Counter 2 state
  logic tb2_evt; // Counter 2 overflow pulse

  // Capture pin edge detection
  logic pin_prev; // Pin one cycle ago
  logic pin_seen; // Prev holds a real sample
  logic pin_edge; // Either edge on the pin
  logic cap_take; // Capture happens now

  // Register decode
  logic sel_csr2; // Offset hit, csr2
  logic sel_reload; // Offset hit, reload
  logic sel_cnt2; // Offset hit, counter 2
  logic sel_csr1; // Offset hit, csr1
  logic sel_cap; // Offset hit, capture
  logic sel_stat; // Offset hit, status
  logic sel_mask; // Offset hit, mask
  logic rd_csr1; // Read of csr1
  logic rd_csr2; // Read of csr2
  logic rd_cap; // Read of capture
  ltc_pkg::ltc_byte_t csr1_view; // Assembled csr1
  ltc_pkg::ltc_byte_t csr2_view; // Assembled csr2
  ltc_pkg::ltc_byte_t next_rd_data; // Read mux output
  ltc_pkg::ltc_byte_t next_irq_status; // Status after set and clear
  ltc_pkg::ltc_byte_t evt_vec; // Events this cycle

  // Control bits into the shared interface
  assign tbi.halt = halt_mode;
  assign tbi.dbl = period_double_sel;

  // Prescaler and hidden timebase counter
  ltc_timebase u_timebase (
    .clk(clk),
    .srst(srst),
    .tb(tbi.timebase)
  );

  // Autoreload counter
  ltc_reload_cnt u_reload_cnt (
    .clk(clk),
    .srst(srst),
    .tb(tbi.counter),
    .reload(counter2_reload),
    .count(counter2_value),
    .ovf(tb2_evt)
  );

  // Address decode
  assign sel_csr2 = (addr == `LTC_OFF_CSR2);
  assign sel_reload = (addr == `LTC_OFF_RELOAD);
  assign sel_cnt2 = (addr == `LTC_OFF_CNT2);
  assign sel_csr1 = (addr == `LTC_OFF_CSR1);
  assign sel_cap = (addr == `LTC_OFF_CAPTURE);
  assign sel_stat = (addr == `LTC_OFF_IRQ_STATUS);
  assign sel_mask = (addr == `LTC_OFF_IRQ_MASK);

  // Reads that clear flags as a side effect
  assign rd_csr1 = rd_en && sel_csr1;
  assign rd_csr2 = rd_en && sel_csr2;
  assign rd_cap = rd_en && sel_cap;

  // Register views; reserved bits read as zero
  assign csr1_view = {capture_irq_en, capture_flag, period_double_sel,
                      timebase1_irq_en, timebase1_flag, 3'h0};
  assign csr2_view = {6'h00, timebase2_irq_en, timebase2_flag};

  // Read mux; unmapped offsets read zero
  assign next_rd_data = sel_csr2 ? csr2_view :
                        sel_reload ? counter2_reload :
                        sel_cnt2 ? counter2_value :
                        sel_csr1 ? csr1_view :
                        sel_cap ? capture_value :
                        sel_stat ? irq_status :
                        sel_mask ? irq_mask : `LTC_RST_BYTE;

  // Edge on the pin, ignored until a first sample exists
  assign pin_edge = pin_seen && (capture_pin != pin_prev);
  // Blocked while the flag stands, so the old value survives
  assign cap_take = pin_edge && !capture_flag;

  // Event vector for the sticky status register
  assign evt_vec = {5'h00, cap_take, tb2_evt, tbi.tb1_evt};
  // Set beats a same-cycle write-one clear
  assign next_irq_status = (wr_en && sel_stat) ?
                           ((irq_status & ~wr_data) | evt_vec) :
                           (irq_status | evt_vec);

  // Read data register, valid only the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= `LTC_RST_BYTE;
    end else begin
      rd_data <= rd_en ? next_rd_data : `LTC_RST_BYTE;
    end
  end

  // Software-owned control bits; flag bits in writes are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      timebase1_irq_en <= 1'b0;
      timebase2_irq_en <= 1'b0;
      capture_irq_en <= 1'b0;
      period_double_sel <= 1'b0;
      counter2_reload <= `LTC_RST_BYTE;
      irq_mask <= `LTC_RST_BYTE;
    end else if (wr_en) begin
      if (sel_csr1) begin
        capture_irq_en <= wr_data[`LTC_CSR1_CAPTURE_IRQ_EN];
        period_double_sel <= wr_data[`LTC_CSR1_DBL];
        timebase1_irq_en <= wr_data[`LTC_CSR1_TIMEBASE1_IRQ_EN];
      end
      if (sel_csr2) begin
        timebase2_irq_en <= wr_data[`LTC_CSR2_TIMEBASE2_IRQ_EN];
      end
      if (sel_reload) begin
        counter2_reload <= wr_data;
      end
      if (sel_mask) begin
        irq_mask <= wr_data;
      end
    end
  end

  // Timebase 1 flag; an overflow on the clearing read still sets it
  always_ff @(posedge clk) begin
    if (srst) begin
      timebase1_flag <= 1'b0;
    end else if (tbi.tb1_evt) begin
      timebase1_flag <= 1'b1;
    end else if (rd_csr1) begin
      timebase1_flag <= 1'b0;
    end
  end

  // Timebase 2 flag, same policy
  always_ff @(posedge clk) begin
    if (srst) begin
      timebase2_flag <= 1'b0;
    end else if (tb2_evt) begin
      timebase2_flag <= 1'b1;
    end else if (rd_csr2) begin
      timebase2_flag <= 1'b0;
    end
  end

  // Capture flag; reset loads LTC_RST_CAP_FLAG, so it starts clear
  always_ff @(posedge clk) begin
    if (srst) begin
      capture_flag <= `LTC_RST_CAP_FLAG;
    end else if (cap_take) begin
      capture_flag <= 1'b1;
    end else if (rd_cap) begin
      capture_flag <= 1'b0;
    end
  end

  // Captured value of the hidden counter
  always_ff @(posedge clk) begin
    if (srst) begin
      capture_value <= `LTC_RST_BYTE;
    end else if (cap_take) begin
      capture_value <= tbi.cnt1;
    end
  end

  // Pin history; pin works in halt to allow wake-up
  // First sample is masked, so a pin already high at release is no edge
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_prev <= 1'b0;
      pin_seen <= 1'b0;
    end else begin
      pin_prev <= capture_pin;
      pin_seen <= 1'b1;
    end
  end

  // Sticky status, cleared by writing ones
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status <= `LTC_RST_BYTE;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt outputs, each from a flop
  // Lines also look at the event, so they rise with the flag, not a cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
      irq_timebase1 <= 1'b0;
      irq_timebase2 <= 1'b0;
      irq_capture <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
      irq_timebase1 <= (timebase1_flag || tbi.tb1_evt) && timebase1_irq_en;
      irq_timebase2 <= (timebase2_flag || tb2_evt) && timebase2_irq_en;
      irq_capture <= (capture_flag || cap_take) && capture_irq_en;
    end
  end

  // Checks on flags, capture and interrupts
  a_tb1_flag_set: assert property (@(posedge clk) disable iff (srst)
    tbi.tb1_evt |=> timebase1_flag) else $error("timebase 1 flag not set");
  a_tb1_read_clear: assert property (@(posedge clk) disable iff (srst)
    rd_csr1 && !tbi.tb1_evt |=> !timebase1_flag) else $error("csr1 read left flag set");
  a_tb1_write_ign: assert property (@(posedge clk) disable iff (srst)
    wr_en && sel_csr1 && !rd_en && !tbi.tb1_evt |=> $stable(timebase1_flag))
    else $error("write changed timebase 1 flag");
  a_tb2_flag_set: assert property (@(posedge clk) disable iff (srst)
    tb2_evt |=> timebase2_flag) else $error("timebase 2 flag not set");
  a_tb2_read_clr: assert property (@(posedge clk) disable iff (srst)
    rd_csr2 && !tb2_evt |=> !timebase2_flag) else $error("csr2 read left flag set");
  a_cap_latch: assert property (@(posedge clk) disable iff (srst)
    cap_take |=> capture_flag && capture_value == $past(tbi.cnt1))
    else $error("capture value or flag wrong");
  a_cap_block: assert property (@(posedge clk) disable iff (srst)
    capture_flag && !rd_cap |=> $stable(capture_value) && capture_flag)
    else $error("capture overwritten while flag set");
  a_cap_read_clr: assert property (@(posedge clk) disable iff (srst)
    rd_cap && !cap_take |=> !capture_flag) else $error("capture read did not clear flag");
  a_halt_freeze: assert property (@(posedge clk) disable iff (srst)
    halt_mode [*2] |-> $stable(tbi.cnt1) && $stable(counter2_value))
    else $error("counter moved in halt");
  a_irq_gate: assert property (@(posedge clk) disable iff (srst)
    timebase1_flag && timebase1_irq_en |=> irq_timebase1)
    else $error("timebase 1 interrupt missing");
  a_tb1_period: assert property (@(posedge clk) disable iff (srst || halt_mode)
    tbi.tb1_evt && !period_double_sel |=> !tbi.tb1_evt [*8])
    else $error("timebase events too close");

  // Writes never touch the hardware-owned flag of csr2
  a_tb2_write_ign: assert property (@(posedge clk) disable iff (srst)
    wr_en && sel_csr2 && !rd_en && !tb2_evt |=> $stable(timebase2_flag))
    else $error("write changed timebase 2 flag");
  // Capture register is read-only; a write must not load it
  a_cap_write_ign: assert property (@(posedge clk) disable iff (srst)
    wr_en && sel_cap && !cap_take |=> $stable(capture_value))
    else $error("write changed capture register");
  // A capture only ever follows a pin edge
  a_cap_from_edge: assert property (@(posedge clk) disable iff (srst)
    $rose(capture_flag) |-> $past(pin_edge)) else $error("capture flag without pin edge");
  // Reload register moves only on a write; counter 2 picks it up later
  a_reload_hold: assert property (@(posedge clk) disable iff (srst)
    !(wr_en && sel_reload) |=> $stable(counter2_reload))
    else $error("reload changed without write");

  // Interrupt lines follow flag and enable
  a_tb2_irq_gate: assert property (@(posedge clk) disable iff (srst)
    timebase2_flag && timebase2_irq_en |=> irq_timebase2)
    else $error("timebase 2 interrupt missing");
  a_cap_irq_gate: assert property (@(posedge clk) disable iff (srst)
    capture_flag && capture_irq_en |=> irq_capture) else $error("capture interrupt missing");
  a_tb1_irq_off: assert property (@(posedge clk) disable iff (srst)
    !timebase1_irq_en |=> !irq_timebase1) else $error("timebase 1 interrupt while disabled");
  a_tb2_irq_off: assert property (@(posedge clk) disable iff (srst)
    !timebase2_irq_en |=> !irq_timebase2) else $error("timebase 2 interrupt while disabled");
  a_cap_irq_off: assert property (@(posedge clk) disable iff (srst)
    !capture_irq_en |=> !irq_capture) else $error("capture interrupt while disabled");
  a_irq_masked: assert property (@(posedge clk) disable iff (srst)
    irq_mask == `LTC_RST_BYTE |=> !irq) else $error("summary interrupt while all masked");

  // Sticky status: every event leaves its bit set
  a_status_sticky: assert property (@(posedge clk) disable iff (srst)
    evt_vec != `LTC_RST_BYTE |=> (irq_status & $past(evt_vec)) == $past(evt_vec))
    else $error("event did not set status bit");
  // Write-one clear, unless the same event arrives in that cycle
  a_status_wclr: assert property (@(posedge clk) disable iff (srst)
    wr_en && sel_stat && wr_data[`LTC_IRQ_TB1] && !tbi.tb1_evt |=> !irq_status[`LTC_IRQ_TB1])
    else $error("status bit not cleared by write");

  // Read data stand one cycle only, zero otherwise
  a_rd_idle: assert property (@(posedge clk) disable iff (srst)
    !rd_en |=> rd_data == `LTC_RST_BYTE) else $error("read data outside read cycle");
  a_rd_csr1: assert property (@(posedge clk) disable iff (srst)
    rd_csr1 |=> rd_data == $past(csr1_view)) else $error("csr1 read data wrong");
  a_rd_capture: assert property (@(posedge clk) disable iff (srst)
    rd_cap |=> rd_data == $past(capture_value)) else $error("capture read data wrong");
  a_rd_cnt2: assert property (@(posedge clk) disable iff (srst)
    rd_en && sel_cnt2 |=> rd_data == $past(counter2_value)) else $error("counter 2 read wrong");

  // Main scenarios
  c_cap_taken: cover property (@(posedge clk) disable iff (srst) cap_take);
  c_reload_ovf: cover property (@(posedge clk) disable iff (srst) tb2_evt);
  c_dbl_event: cover property (@(posedge clk) disable iff (srst)
    tbi.tb1_evt && period_double_sel);
  c_set_on_clear: cover property (@(posedge clk) disable iff (srst) tbi.tb1_evt && rd_csr1);
  // Halt held for several cycles in a row
  c_halt_held: cover property (@(posedge clk) disable iff (srst) halt_mode [*8]);
endmodule // ltc_timer

// *** verification/ltc_timer_test.sv ***
// Self-checking testbench of the lite timebase and capture timer
`timescale 1ns/1ps
`include "ltc_cfg.svh"
module ltc_timer_test;
  // Stimulus and observed outputs
  logic clk;
  logic srst;
  logic [7:0] addr;
  ltc_pkg::ltc_byte_t wr_data;
  logic wr_en;
  logic rd_en;
  ltc_pkg::ltc_byte_t rd_data;
  logic capture_pin;
  logic halt_mode;
  logic irq;
  logic irq_timebase1;
  logic irq_timebase2;
  logic irq_capture;
  // Bookkeeping
  int fails;
  int checks;
  int cyc;
  // Interrupt lines by index, for the bounded waits
  wire [2:0] lines = {irq_capture, irq_timebase2, irq_timebase1};

  ltc_timer uut (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .capture_pin(capture_pin), .halt_mode(halt_mode),
    .irq(irq), .irq_timebase1(irq_timebase1), .irq_timebase2(irq_timebase2),
    .irq_capture(irq_capture));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle count; non-blocking so tasks woken at the edge see the old value
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      $display("ERROR %0t run exceeded cycle ceiling", $time);
      tally_and_finish;
    end
  end

  // Counts and verdict, the single exit point
  task tally_and_finish;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compare a register byte
  task chk_byte(input ltc_pkg::ltc_byte_t got, input ltc_pkg::ltc_byte_t exp, input string m);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Compare a single output line
  task chk_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  // Compare a measured interval in clocks
  task chk_int(input int got, input int exp, input string m);
    checks++;
    if (got != exp) begin
      fails++;
      $display("ERROR %0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  // Let n falling edges pass; outputs are settled there
  task cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle write strobe
  task wr(input logic [7:0] a, input ltc_pkg::ltc_byte_t d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task rd(input logic [7:0] a, output ltc_pkg::ltc_byte_t d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask

  // Read and compare in one go
  task rd_chk(input logic [7:0] a, input ltc_pkg::ltc_byte_t exp, input string m);
    ltc_pkg::ltc_byte_t v;
    rd(a, v);
    chk_byte(v, exp, m);
  endtask

  // Wait for an interrupt line under a bound, return the cycle it was seen
  task wait_line(input int i, output int t);
    int n;
    n = 0;
    while (lines[i] !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      $display("ERROR %0t interrupt line %0d never rose", $time, i);
    end
    t = cyc;
  endtask

  // Toggle the capture pin at an exact cycle, so captures are a known tick apart
  task pin_at(input int t);
    while (cyc < t) @(posedge clk);
    capture_pin <= ~capture_pin;
  endtask

  // Reset values, reserved bits, read-only and unmapped places
  task test_reset;
    for (int a = 8; a <= 14; a++) begin
      rd_chk(8'(a), 8'h00, "reset value");
    end
    rd_chk(8'h20, 8'h00, "unmapped read");
    wr(`LTC_OFF_CSR2, 8'hFF);
    rd_chk(`LTC_OFF_CSR2, 8'h02, "csr2 flag not writable");
    wr(`LTC_OFF_CSR2, 8'h00);
    wr(`LTC_OFF_CAPTURE, 8'h55);
    rd_chk(`LTC_OFF_CAPTURE, 8'h00, "capture read-only");
    $display("test reset done");
  endtask

  // Reload applied only at overflow, overflow intervals, flag clear by read
  task test_counter2;
    int t0;
    int t1;
    int t2;
    ltc_pkg::ltc_byte_t v;
    wr(`LTC_OFF_CSR2, 8'h02);
    wr(`LTC_OFF_RELOAD, 8'hF0);
    wait_line(1, t0);
    rd_chk(`LTC_OFF_CNT2, 8'hF0, "reload after FF");
    rd_chk(`LTC_OFF_CSR2, 8'h03, "tb2 flag set");
    rd_chk(`LTC_OFF_CSR2, 8'h02, "tb2 flag cleared");
    cycles(2);
    chk_bit(irq_timebase2, 1'b0, "tb2 line after clear");
    // New reload mid-run must not disturb the current run
    wr(`LTC_OFF_RELOAD, 8'hC0);
    wait_line(1, t1);
    chk_int(t1 - t0, 16 * `LTC_PRESCALE, "run from F0");
    rd_chk(`LTC_OFF_CNT2, 8'hC0, "new reload taken");
    rd(`LTC_OFF_CSR2, v);
    cycles(3);
    wait_line(1, t2);
    chk_int(t2 - t1, 64 * `LTC_PRESCALE, "run from C0");
    rd(`LTC_OFF_CSR2, v);
    $display("test counter2 done");
  endtask

  // Full halt freezes counting, release resumes it
  task test_halt;
    ltc_pkg::ltc_byte_t a;
    ltc_pkg::ltc_byte_t c;
    @(posedge clk);
    halt_mode <= 1'b1;
    cycles(2);
    rd(`LTC_OFF_CNT2, a);
    cycles(100);
    rd_chk(`LTC_OFF_CNT2, a, "frozen in halt");
    @(posedge clk);
    halt_mode <= 1'b0;
    cycles(70);
    rd(`LTC_OFF_CNT2, c);
    chk_bit(c !== a, 1'b1, "counts after halt");
    $display("test halt done");
  endtask

  // Timebase period, flag clear by read, status and mask, doubled period
  task test_timebase1;
    int t0;
    int t1;
    ltc_pkg::ltc_byte_t v;
    wr(`LTC_OFF_IRQ_MASK, 8'h01);
    wr(`LTC_OFF_CSR1, 8'h10);
    // Flag and status are left over from earlier wraps; drop them so t0 is a real event
    rd(`LTC_OFF_CSR1, v);
    wr(`LTC_OFF_IRQ_STATUS, 8'h07);
    cycles(2);
    wait_line(0, t0);
    chk_bit(irq, 1'b1, "summary irq raised");
    wr(`LTC_OFF_CSR1, 8'h10);
    rd_chk(`LTC_OFF_CSR1, 8'h18, "tb1 flag survives write");
    rd_chk(`LTC_OFF_CSR1, 8'h10, "tb1 flag cleared");
    cycles(2);
    chk_bit(irq_timebase1, 1'b0, "tb1 line after clear");
    chk_bit(irq, 1'b1, "status sticky");
    rd(`LTC_OFF_IRQ_STATUS, v);
    chk_bit(v[`LTC_IRQ_TB1], 1'b1, "status bit");
    wr(`LTC_OFF_IRQ_MASK, 8'h00);
    cycles(2);
    chk_bit(irq, 1'b0, "masked");
    wr(`LTC_OFF_IRQ_MASK, 8'h01);
    cycles(2);
    chk_bit(irq, 1'b1, "unmasked");
    wr(`LTC_OFF_IRQ_STATUS, 8'h07);
    cycles(2);
    chk_bit(irq, 1'b0, "status cleared");
    wait_line(0, t1);
    chk_int(t1 - t0, `LTC_TB_PERIOD_OSC, "normal period");
    rd(`LTC_OFF_CSR1, v);
    // Doubled period; the first event after the switch is discarded
    wr(`LTC_OFF_CSR1, 8'h30);
    wait_line(0, t0);
    rd_chk(`LTC_OFF_CSR1, 8'h38, "flag with double");
    cycles(3);
    wait_line(0, t1);
    chk_int(t1 - t0, `LTC_TB_PERIOD_DBL_OSC, "doubled period");
    rd(`LTC_OFF_CSR1, v);
    wr(`LTC_OFF_CSR1, 8'h00);
    $display("test timebase1 done");
  endtask

  // Pin edges two ticks apart; a blocked edge while the flag is set
  task test_capture;
    int base;
    ltc_pkg::ltc_byte_t v1;
    ltc_pkg::ltc_byte_t v2;
    wr(`LTC_OFF_CSR1, 8'h80);
    rd(`LTC_OFF_CAPTURE, v1);
    base = cyc + 4;
    pin_at(base);
    cycles(3);
    chk_bit(irq_capture, 1'b1, "capture line");
    rd_chk(`LTC_OFF_CSR1, 8'hC0, "capture flag set");
    pin_at(base + 64);
    rd(`LTC_OFF_CAPTURE, v1);
    cycles(2);
    chk_bit(irq_capture, 1'b0, "flag cleared by read");
    pin_at(base + 128);
    cycles(3);
    rd(`LTC_OFF_CAPTURE, v2);
    chk_byte(v2, 8'((int'(v1) + 4) % 250), "blocked edge kept");
    pin_at(base + 192);
    cycles(3);
    rd(`LTC_OFF_CAPTURE, v2);
    chk_byte(v2, 8'((int'(v1) + 6) % 250), "falling edge capture");
    $display("test capture done");
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    capture_pin = 1'b0;
    halt_mode = 1'b0;
    cyc = 0;
    fails = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    test_reset;
    test_counter2;
    test_halt;
    test_timebase1;
    test_capture;
    tally_and_finish;
  end
endmodule // ltc_timer_test
